/* acr_top.sv */
/*
 * Audio clock regeneration and pixel repetition control: AHB-Lite
 * register slave, N and CTS registers, CTS source mux, measurement and
 * repetition selection.
 * Assumes the link clock and audio reference pins toggle well below
 * half of hclk; both are sampled as levels.
 */
// The implementer's own choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - average CTS equals link clock times N over 128*fs.
// - non-integer CTS alternates between neighbouring integers.
// - select bit set sends the programmed external CTS.
// - select bit clear sends measured CTS, readable in status registers.
// - two-bit field selects averaging of the measured CTS.
// - averaging 00 none, 01 four, 10 eight, 11 sixteen; reset 10.
// - CTS counts link clocks per N reference periods.
// - repetition doubles or quadruples link clock when required.
// - mode field 00 auto, 01 max, 1x manual.
// - auto derives factor from format and sample rate; factor readable.
// - manual applies the host-written factor.
// - max uses largest factor allowed for format.
// - double-width interlaced and 240p/288p formats repeat twice.
// - 2880-wide up to max, 1440p formats one or two times.
// - sample rate codes 3,0,2,8,A,C,E for 32 to 192 kHz.
module acr_top
    import acr_pkg::*;
#(
    parameter logic [7:0] REV_ID = 8'h5A // arbitrary value
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic      [31:0] hrdata,
    output logic             hresp,
    input  wire logic        tmds_clk_pin,
    input  wire logic        aref_pin,
    output var acr_out_t     acr_out,
    output logic      [1:0]  rep_fac
);

    typedef struct packed {
        logic [2:0]  tmds_sync;
        logic [2:0]  aref_sync;
        logic        wr_pend;
        logic [7:0]  wr_idx;
        logic [31:0] rdata;
        logic [19:0] n;
        logic [19:0] cts_ext;
        logic        cts_sel;
        logic [1:0]  avg;
        logic [3:0]  rate;
        logic [6:0]  vic;
        logic [1:0]  rep_mode;
        logic [1:0]  rep_man;
        logic [15:0] shadow;
        acr_out_t    out;
    } acr_top_st_t;

    acr_top_st_t st_r;
    acr_top_st_t st_nxt;

    logic         tmds_tick;
    logic         aref_tick;
    logic [19:0]  cts_int;
    logic         cts_upd;
    logic         req;
    logic [7:0]   idx;
    logic [7:0]   wb;
    logic [31:0]  rd_word;
    acr_rep_cfg_t rep_cfg;

    assign tmds_tick = st_r.tmds_sync[1] & ~st_r.tmds_sync[2];
    assign aref_tick = st_r.aref_sync[1] & ~st_r.aref_sync[2];

    assign rep_cfg.mode   = st_r.rep_mode;
    assign rep_cfg.manual = st_r.rep_man;
    assign rep_cfg.vic    = st_r.vic;
    assign rep_cfg.rate   = st_r.rate;

    acr_cts_meas #(
        .NW (ACR_NW)
    ) u_meas (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .tmds_tick (tmds_tick),
        .aref_tick (aref_tick),
        .n_val     (st_r.n),
        .avg_mode  (st_r.avg),
        .cts_int   (cts_int),
        .cts_upd   (cts_upd)
    );

    acr_pixrep u_rep (
        .hclk    (hclk),
        .hresetn (hresetn),
        .cfg     (rep_cfg),
        .rep_fac (rep_fac)
    );

    assign req = hsel & htrans[1];
    assign idx = haddr[9:2];
    assign wb  = hwdata[7:0];

    // read mux, taken in the address phase
    always_comb begin
        rd_word = 32'h0000_0000;
        case (idx)
            ACR_IDX_REV:     rd_word[7:0] = REV_ID;
            ACR_IDX_N_HI:    rd_word[3:0] = st_r.n[19:16];
            ACR_IDX_N_MD:    rd_word[7:0] = st_r.n[15:8];
            ACR_IDX_N_LO:    rd_word[7:0] = st_r.n[7:0];
            ACR_IDX_CTSI_HI: begin
                rd_word[7:4] = st_r.rate;
                rd_word[3:0] = cts_int[19:16];
            end
            ACR_IDX_CTSI_MD: rd_word[7:0] = st_r.shadow[15:8];
            ACR_IDX_CTSI_LO: rd_word[7:0] = st_r.shadow[7:0];
            ACR_IDX_CTSE_HI: rd_word[3:0] = st_r.cts_ext[19:16];
            ACR_IDX_CTSE_MD: rd_word[7:0] = st_r.cts_ext[15:8];
            ACR_IDX_CTSE_LO: rd_word[7:0] = st_r.cts_ext[7:0];
            ACR_IDX_CTRL: begin
                rd_word[ACR_CTRL_SEL_BIT] = st_r.cts_sel;
                rd_word[ACR_CTRL_AVG_LSB +: 2] = st_r.avg;
            end
            ACR_IDX_AFS: rd_word[ACR_AFS_RATE_LSB +: 4] = st_r.rate;
            ACR_IDX_REP_CTRL: begin
                rd_word[ACR_REP_MODE_LSB +: 2] = st_r.rep_mode;
                rd_word[ACR_REP_MAN_LSB +: 2]  = st_r.rep_man;
            end
            ACR_IDX_VIC:      rd_word[6:0] = st_r.vic;
            ACR_IDX_REP_STAT: rd_word[ACR_REP_STAT_LSB +: 2] = rep_fac;
            default:          rd_word = 32'h0000_0000;
        endcase
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.tmds_sync = {st_r.tmds_sync[1:0], tmds_clk_pin};
        st_nxt.aref_sync = {st_r.aref_sync[1:0], aref_pin};

        // write data phase; lands once, a stall clears the pending flag
        if (st_r.wr_pend) begin
            case (st_r.wr_idx)
                ACR_IDX_N_HI:    st_nxt.n[19:16] = wb[3:0];
                ACR_IDX_N_MD:    st_nxt.n[15:8]  = wb;
                ACR_IDX_N_LO:    st_nxt.n[7:0]   = wb;
                ACR_IDX_CTSE_HI: st_nxt.cts_ext[19:16] = wb[3:0];
                ACR_IDX_CTSE_MD: st_nxt.cts_ext[15:8]  = wb;
                ACR_IDX_CTSE_LO: st_nxt.cts_ext[7:0]   = wb;
                ACR_IDX_CTRL: begin
                    st_nxt.cts_sel = wb[ACR_CTRL_SEL_BIT];
                    st_nxt.avg = wb[ACR_CTRL_AVG_LSB +: 2];
                end
                ACR_IDX_AFS: st_nxt.rate = wb[ACR_AFS_RATE_LSB +: 4];
                ACR_IDX_REP_CTRL: begin
                    st_nxt.rep_mode = wb[ACR_REP_MODE_LSB +: 2];
                    st_nxt.rep_man  = wb[ACR_REP_MAN_LSB +: 2];
                end
                ACR_IDX_VIC: st_nxt.vic = wb[6:0];
                default: st_nxt.vic = st_r.vic;
            endcase
        end

        // address phase capture
        if (hready) begin
            st_nxt.wr_pend = req & hwrite & (hsize == 3'h2);
            st_nxt.wr_idx  = idx;
            if (req && !hwrite) begin
                st_nxt.rdata = rd_word;
                if (idx == ACR_IDX_CTSI_HI) begin
                    st_nxt.shadow = cts_int[15:0];
                end
            end
        end else begin
            // stalled read: the pending write lands now, stall ends
            st_nxt.wr_pend = 1'b0;
        end

        // link-side values
        st_nxt.out.n   = st_r.n;
        st_nxt.out.cts = st_r.cts_sel ? st_r.cts_ext : cts_int;
        st_nxt.out.stb = cts_upd;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r         <= '0;
            st_r.n       <= ACR_N_RST;
            st_r.cts_ext <= ACR_CTS_RST;
            st_r.avg     <= ACR_AVG_RST;
            st_r.rate    <= ACR_RATE_RST;
            st_r.vic     <= ACR_VIC_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // a read right behind a write waits one cycle for the write
    assign hreadyout = ~(st_r.wr_pend & req & ~hwrite);
    assign hrdata    = st_r.rdata;
    assign hresp     = 1'b0;
    assign acr_out   = st_r.out;

endmodule : acr_top
`default_nettype wire

/* acr_pkg.sv */
/*
 * Shared constants and carriers for the audio clock regeneration and
 * pixel repetition block: register indices, field positions, reset
 * values, sample-rate and repetition encodings.
 * Assumes a 32-bit AHB-Lite register bus, one word per register index.
 */
package acr_pkg;

    localparam int ACR_NW = 20;

    // register indices; byte address = 4 * index
    localparam logic [7:0] ACR_IDX_REV      = 8'h00;
    localparam logic [7:0] ACR_IDX_N_HI     = 8'h01;
    localparam logic [7:0] ACR_IDX_N_MD     = 8'h02;
    localparam logic [7:0] ACR_IDX_N_LO     = 8'h03;
    localparam logic [7:0] ACR_IDX_CTSI_HI  = 8'h04;
    localparam logic [7:0] ACR_IDX_CTSI_MD  = 8'h05;
    localparam logic [7:0] ACR_IDX_CTSI_LO  = 8'h06;
    localparam logic [7:0] ACR_IDX_CTSE_HI  = 8'h07;
    localparam logic [7:0] ACR_IDX_CTSE_MD  = 8'h08;
    localparam logic [7:0] ACR_IDX_CTSE_LO  = 8'h09;
    localparam logic [7:0] ACR_IDX_CTRL     = 8'h0A;
    localparam logic [7:0] ACR_IDX_AFS      = 8'h15;
    localparam logic [7:0] ACR_IDX_REP_CTRL = 8'h3B;
    localparam logic [7:0] ACR_IDX_VIC      = 8'h3C;
    localparam logic [7:0] ACR_IDX_REP_STAT = 8'h3D;

    // field positions
    localparam int ACR_CTRL_SEL_BIT  = 7;
    localparam int ACR_CTRL_AVG_LSB  = 5;
    localparam int ACR_AFS_RATE_LSB  = 4;
    localparam int ACR_REP_MODE_LSB  = 5;
    localparam int ACR_REP_MAN_LSB   = 3;
    localparam int ACR_REP_STAT_LSB  = 6;

    // reset values
    localparam logic [1:0]  ACR_AVG_RST  = 2'h2;
    localparam logic [19:0] ACR_N_RST    = 20'h0_0000;
    localparam logic [19:0] ACR_CTS_RST  = 20'h0_0000;
    localparam logic [3:0]  ACR_RATE_RST = 4'h0;
    localparam logic [6:0]  ACR_VIC_RST  = 7'h00;

    // averaging encodings
    localparam logic [1:0] ACR_AVG_NONE = 2'h0;
    localparam logic [1:0] ACR_AVG_4    = 2'h1;
    localparam logic [1:0] ACR_AVG_8    = 2'h2;
    localparam logic [1:0] ACR_AVG_16   = 2'h3;

    // audio sample rate codes
    localparam logic [3:0] ACR_FS_32K   = 4'h3;
    localparam logic [3:0] ACR_FS_44K1  = 4'h0;
    localparam logic [3:0] ACR_FS_48K   = 4'h2;
    localparam logic [3:0] ACR_FS_88K2  = 4'h8;
    localparam logic [3:0] ACR_FS_96K   = 4'hA;
    localparam logic [3:0] ACR_FS_176K4 = 4'hC;
    localparam logic [3:0] ACR_FS_192K  = 4'hE;

    // repetition mode and factor encodings
    localparam logic [1:0] ACR_REP_AUTO = 2'h0;
    localparam logic [1:0] ACR_REP_MAX  = 2'h1;
    localparam logic [1:0] ACR_REP_X1   = 2'h0;
    localparam logic [1:0] ACR_REP_X2   = 2'h1;
    localparam logic [1:0] ACR_REP_X4   = 2'h2;

    typedef struct packed {
        logic [1:0] mode;
        logic [1:0] manual;
        logic [6:0] vic;
        logic [3:0] rate;
    } acr_rep_cfg_t;

    typedef struct packed {
        logic [19:0] n;
        logic [19:0] cts;
        logic        stb;
    } acr_out_t;

endpackage : acr_pkg

/* acr_cts_meas.sv */
/*
 * CTS measurement: counts link-clock ticks over N reference ticks and
 * optionally averages 4, 8 or 16 intervals, carrying the remainder.
 * Assumes both tick inputs are one-cycle pulses already synchronised.
 */
`timescale 1ns/1ps
`default_nettype none
module acr_cts_meas
    import acr_pkg::*;
#(
    parameter int NW = ACR_NW
) (
    input  wire logic          hclk,
    input  wire logic          hresetn,
    input  wire logic          tmds_tick,
    input  wire logic          aref_tick,
    input  wire logic [NW-1:0] n_val,
    input  wire logic [1:0]    avg_mode,
    output logic      [NW-1:0] cts_int,
    output logic               cts_upd
);

    typedef struct packed {
        logic [NW-1:0] div;
        logic [NW-1:0] cnt;
        logic [NW+4:0] acc;
        logic [3:0]    nsmp;
        logic [1:0]    mode;
        logic [NW-1:0] cts;
        logic          upd;
    } acr_meas_st_t;

    acr_meas_st_t st_r;
    acr_meas_st_t st_nxt;

    logic [NW-1:0] cnt_inc;
    logic [NW+4:0] sum;
    logic [3:0]    last;
    logic [2:0]    shift;
    logic          restart;
    logic [NW+4:0] acc_in;
    logic [3:0]    nsmp_in;

    always_comb begin
        st_nxt       = st_r;
        st_nxt.upd   = 1'b0;
        cnt_inc      = st_r.cnt + NW'(tmds_tick);
        st_nxt.cnt   = cnt_inc;
        // averaging window restarts on a mode change; ticks still count
        restart      = avg_mode != st_r.mode;
        acc_in       = restart ? '0 : st_r.acc;
        nsmp_in      = restart ? 4'h0 : st_r.nsmp;
        sum          = acc_in + (NW+5)'(cnt_inc);
        case (avg_mode)
            ACR_AVG_4: begin
                last  = 4'h3;
                shift = 3'd2;
            end
            ACR_AVG_8: begin
                last  = 4'h7;
                shift = 3'd3;
            end
            default: begin
                last  = 4'hF;
                shift = 3'd4;
            end
        endcase
        st_nxt.mode = avg_mode;
        st_nxt.acc  = acc_in;
        st_nxt.nsmp = nsmp_in;
        if (aref_tick && n_val != '0) begin
            if (st_r.div >= n_val - NW'(1)) begin
                st_nxt.div = '0;
                st_nxt.cnt = '0;
                if (avg_mode == ACR_AVG_NONE) begin
                    st_nxt.cts = cnt_inc;
                    st_nxt.upd = 1'b1;
                end else if (nsmp_in == last) begin
                    // remainder kept: output alternates on fractions
                    st_nxt.cts  = NW'(sum >> shift);
                    st_nxt.acc  = sum & ((NW+5)'(1) << shift) - 1'b1;
                    st_nxt.nsmp = '0;
                    st_nxt.upd  = 1'b1;
                end else begin
                    st_nxt.acc  = sum;
                    st_nxt.nsmp = nsmp_in + 4'h1;
                end
            end else begin
                st_nxt.div = st_r.div + NW'(1);
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r      <= '0;
            st_r.mode <= ACR_AVG_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign cts_int = st_r.cts;
    assign cts_upd = st_r.upd;

endmodule : acr_cts_meas
`default_nettype wire

/* acr_pixrep.sv */
/*
 * Pixel repetition factor selection in auto, max or manual mode from
 * the video format code and audio sample rate code.
 * Assumes configuration comes from registers on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module acr_pixrep
    import acr_pkg::*;
(
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire acr_rep_cfg_t cfg,
    output logic [1:0]        rep_fac
);

    typedef struct packed {
        logic [1:0] fac;
    } acr_rep_st_t;

    acr_rep_st_t st_r;
    acr_rep_st_t st_nxt;

    logic dbl;
    logic wide;
    logic p1440;
    logic hi_fs;
    logic top_fs;
    logic [1:0] max_fac;
    logic [1:0] auto_fac;

    always_comb begin
        // format classes
        dbl   = (cfg.vic >= 7'd6 && cfg.vic <= 7'd9) ||
                (cfg.vic >= 7'd21 && cfg.vic <= 7'd24);
        wide  = (cfg.vic >= 7'd10 && cfg.vic <= 7'd13) ||
                (cfg.vic >= 7'd25 && cfg.vic <= 7'd28);
        p1440 = cfg.vic == 7'd14 || cfg.vic == 7'd15 ||
                cfg.vic == 7'd29 || cfg.vic == 7'd30;
        top_fs = cfg.rate == ACR_FS_176K4 || cfg.rate == ACR_FS_192K;
        hi_fs  = top_fs || cfg.rate == ACR_FS_88K2 ||
                 cfg.rate == ACR_FS_96K;
        if (wide) begin
            max_fac = ACR_REP_X4;
        end else if (dbl || p1440) begin
            max_fac = ACR_REP_X2;
        end else begin
            max_fac = ACR_REP_X1;
        end
        // higher rates need more blanking bandwidth
        if (dbl) begin
            auto_fac = ACR_REP_X2;
        end else if (wide) begin
            auto_fac = top_fs ? ACR_REP_X4 :
                       (hi_fs ? ACR_REP_X2 : ACR_REP_X1);
        end else if (p1440) begin
            auto_fac = hi_fs ? ACR_REP_X2 : ACR_REP_X1;
        end else begin
            auto_fac = ACR_REP_X1;
        end
        st_nxt = st_r;
        if (cfg.mode[1]) begin
            st_nxt.fac = cfg.manual;
        end else if (cfg.mode == ACR_REP_MAX) begin
            st_nxt.fac = max_fac;
        end else begin
            st_nxt.fac = auto_fac;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rep_fac = st_r.fac;

endmodule : acr_pixrep
`default_nettype wire

/* acr_top_properties.sv */
/*
 * Checker for acr_top: bus answer timing, read data hold, output causes.
 * Assumes it is bound to acr_top and sees only that module's ports.
 */
`timescale 1ns/1ps
`default_nettype none
module acr_top_properties
    import acr_pkg::*;
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic        hresp,
    input wire logic        tmds_clk_pin,
    input wire logic        aref_pin,
    input wire acr_out_t    acr_out,
    input wire logic [1:0]  rep_fac
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    logic       wdp_r;
    logic [2:0] wage_r;
    logic       rd_take;

    assign rd_take = hsel && htrans[1] && hready && !hwrite;

    // cycles since the last write data phase, saturating at 7
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wdp_r  <= 1'b0;
            wage_r <= 3'h7;
        end else begin
            wdp_r  <= hsel && htrans[1] && hready && hwrite;
            wage_r <= wdp_r ? 3'h0 : wage_r + {2'h0, wage_r != 3'h7};
        end
    end

    a_resp_okay: assert property (hresp == 1'b0)
        else $error("slave response not okay");
    a_stall_cause: assert property
        (!hreadyout |-> wdp_r && hsel && htrans[1] && !hwrite)
        else $error("wait state without read after write");
    a_stall_single: assert property (!hreadyout |=> hreadyout)
        else $error("wait state longer than one cycle");
    a_stb_pulse: assert property (acr_out.stb |=> !acr_out.stb)
        else $error("update strobe longer than one cycle");
    a_rdata_hold: assert property ($changed(hrdata) |-> $past(rd_take))
        else $error("read data changed without a read");
    a_rdata_upper: assert property (hrdata[31:8] == 24'h0)
        else $error("unused read data bits not zero");
    a_n_after_write: assert property
        ($changed(acr_out.n) |-> wage_r < 3'h4)
        else $error("n output changed without a write");
    a_cts_cause: assert property
        ($changed(acr_out.cts) |-> acr_out.stb || wage_r < 3'h5)
        else $error("cts changed without update or write");
    a_rep_after_write: assert property
        ($changed(rep_fac) |-> wage_r < 3'h5)
        else $error("repetition factor changed without a write");
endmodule : acr_top_properties

bind acr_top acr_top_properties u_props (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hrdata,
    .hresp, .tmds_clk_pin, .aref_pin, .acr_out, .rep_fac);
`default_nettype wire

/* acr_sink_model.sv */
/*
 * Sink side model: latches each n and cts pair as a clock regenerator
 * would, and counts them.
 * Assumes acr_out is registered on hclk.
 */
`timescale 1ns/1ps
`default_nettype none
module acr_sink_model
    import acr_pkg::*;
(
    input wire logic      hclk,
    input wire logic      hresetn,
    input wire acr_out_t  acr_in,
    output logic [19:0]   cts_q,
    output logic [19:0]   n_q,
    output var int unsigned pkt_cnt
);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cts_q   <= 20'h0_0000;
            n_q     <= 20'h0_0000;
            pkt_cnt <= 0;
        end else if (acr_in.stb) begin
            cts_q   <= acr_in.cts;
            n_q     <= acr_in.n;
            pkt_cnt <= pkt_cnt + 1;
        end
    end
endmodule : acr_sink_model
`default_nettype wire

/* acr_top_tb.sv */
/*
 * Testbench for acr_top: AHB-Lite tasks, pin clocks, sink model.
 * Assumes acr_pkg, acr_top, the checker and the sink model are compiled.
 */
`timescale 1ns/1ps
`default_nettype none
module acr_top_tb
    import acr_pkg::*;
;
    localparam logic [7:0] RI [13] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h07,
        8'h08, 8'h09, 8'h0A, 8'h15, 8'h3B, 8'h3C, 8'h3D, 8'h20};
    localparam logic [7:0] RV [13] = '{8'h5A, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    // mode, manual factor, video code, rate code, expected factor
    localparam logic [16:0] RT [16] = '{
        {4'h0, 7'h06, ACR_FS_48K, 2'h1}, {4'h0, 7'h15, ACR_FS_32K, 2'h1},
        {4'h0, 7'h04, ACR_FS_192K, 2'h0}, {4'h0, 7'h0A, ACR_FS_192K, 2'h2},
        {4'h0, 7'h19, ACR_FS_176K4, 2'h2}, {4'h0, 7'h0C, ACR_FS_96K, 2'h1},
        {4'h0, 7'h1B, ACR_FS_88K2, 2'h1}, {4'h0, 7'h0A, ACR_FS_44K1, 2'h0},
        {4'h0, 7'h0E, ACR_FS_88K2, 2'h1}, {4'h0, 7'h1D, ACR_FS_48K, 2'h0},
        {4'h4, 7'h0A, ACR_FS_32K, 2'h2}, {4'h4, 7'h1E, ACR_FS_32K, 2'h1},
        {4'h4, 7'h08, ACR_FS_44K1, 2'h1}, {4'h4, 7'h10, ACR_FS_192K, 2'h0},
        {4'hA, 7'h06, ACR_FS_32K, 2'h2}, {4'hC, 7'h06, ACR_FS_48K, 2'h0}};

    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    logic        hready;
    logic        hreadyout;
    logic [31:0] hrdata;
    logic        hresp;
    logic        tmds_clk_pin = 1'b0;
    logic        aref_pin = 1'b0;
    acr_out_t    acr_out;
    logic [1:0]  rep_fac;
    logic [19:0] snk_cts;
    logic [19:0] snk_n;
    int unsigned snk_cnt;
    int          mismatches = 0;
    int          cmp_count = 0;
    int          ah = 8;
    int          pc = 0;
    int          ac = 0;
    int          lo_n;
    int          hi_n;
    logic [31:0] rdv;
    logic [16:0] e;

    assign hready = hreadyout;
    always #5 hclk = ~hclk;
    // link clock at hclk/4, reference half period of ah cycles
    always @(posedge hclk) begin
        pc <= pc + 1;
        if (pc % 2 == 1) tmds_clk_pin <= ~tmds_clk_pin;
        ac <= (ac >= ah - 1) ? 0 : ac + 1;
        if (ac >= ah - 1) aref_pin <= ~aref_pin;
    end

    acr_top DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready, .hreadyout, .hrdata, .hresp, .tmds_clk_pin,
        .aref_pin, .acr_out, .rep_fac);
    acr_sink_model u_sink (.hclk, .hresetn, .acr_in(acr_out),
        .cts_q(snk_cts), .n_q(snk_n), .pkt_cnt(snk_cnt));

    task automatic xfer(input logic w, input logic [7:0] idx,
                        input logic [31:0] wd);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr  <= {22'h0, idx, 2'b00};
        do @(posedge hclk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rdv = hrdata;
    endtask : xfer

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: %s got %h want %h",
                     $time, what, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        xfer(1'b1, idx, {24'h0, d});
    endtask : wr

    task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
        xfer(1'b0, idx, 32'h0000_0000);
        chk(rdv, {24'h0, exp}, "read data");
    endtask : rd

    task automatic wait_pkts(input int k);
        int t0;
        int n;
        t0 = snk_cnt;
        n = 0;
        while (snk_cnt < t0 + k && n < 5000) begin
            @(posedge hclk);
            n++;
        end
        chk(32'(n < 5000), 32'h0000_0001, "no cts update");
    endtask : wait_pkts

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test

    initial begin
        #400_000;
        mismatches++;
        finish_test();
    end

    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk({12'h0, acr_out.cts}, 32'h0000_0000, "cts at reset");
        foreach (RI[i]) rd(RI[i], RV[i]);
        $display("reset values done");
        wr(ACR_IDX_N_HI, 8'hAB);
        wr(ACR_IDX_N_MD, 8'hCD);
        wr(ACR_IDX_N_LO, 8'hEF);
        rd(ACR_IDX_N_HI, 8'h0B);
        chk({12'h0, acr_out.n}, 32'h000B_CDEF, "n output");
        wr(8'h20, 8'hFF);
        rd(8'h20, 8'h00);
        $display("n load done");
        wr(ACR_IDX_N_HI, 8'h00);
        wr(ACR_IDX_N_MD, 8'h00);
        wr(ACR_IDX_N_LO, 8'h04);
        for (int a = 0; a < 4; a++) begin
            wr(ACR_IDX_CTRL, {1'b0, 2'(a), 5'h00});
            rd(ACR_IDX_CTRL, {1'b0, 2'(a), 5'h00});
            wait_pkts(3);
            chk({12'h0, acr_out.cts}, 32'h0000_0010, "cts");
            chk({12'h0, snk_cts}, 32'h0000_0010, "sink cts");
        end
        rd(ACR_IDX_CTSI_HI, 8'h00);
        rd(ACR_IDX_CTSI_MD, 8'h00);
        rd(ACR_IDX_CTSI_LO, 8'h10);
        $display("measured cts done");
        ah = 9;
        wr(ACR_IDX_N_LO, 8'h03);
        wr(ACR_IDX_CTRL, 8'h20);
        wait_pkts(2);
        lo_n = 0;
        hi_n = 0;
        repeat (8) begin
            wait_pkts(1);
            lo_n += int'(acr_out.cts === 20'h0_000D);
            hi_n += int'(acr_out.cts === 20'h0_000E);
        end
        chk(32'(lo_n + hi_n), 32'h0000_0008, "cts off neighbours");
        chk(32'(lo_n > 0 && hi_n > 0), 32'h0000_0001, "no alternation");
        $display("alternating cts done");
        wr(ACR_IDX_CTSE_HI, 8'h01);
        wr(ACR_IDX_CTSE_MD, 8'h22);
        wr(ACR_IDX_CTSE_LO, 8'h0A);
        wr(ACR_IDX_CTRL, 8'h80);
        repeat (4) @(posedge hclk);
        chk({12'h0, acr_out.cts}, 32'h0001_220A, "external cts");
        repeat (300) @(posedge hclk);
        chk({12'h0, acr_out.cts}, 32'h0001_220A, "external cts");
        wr(ACR_IDX_N_MD, 8'h10);
        wr(ACR_IDX_N_LO, 8'h00);
        rd(ACR_IDX_N_MD, 8'h10);
        chk({12'h0, acr_out.n}, 32'h0000_1000, "coherent n");
        wr(ACR_IDX_CTRL, 8'h00);
        $display("external cts done");
        foreach (RT[i]) begin
            e = RT[i];
            wr(ACR_IDX_AFS, {e[5:2], 4'h0});
            wr(ACR_IDX_VIC, {1'b0, e[12:6]});
            wr(ACR_IDX_REP_CTRL, {1'b0, e[16:13], 3'h0});
            repeat (4) @(posedge hclk);
            chk({30'h0, rep_fac}, {30'h0, e[1:0]}, "factor");
            rd(ACR_IDX_REP_STAT, {e[1:0], 6'h00});
        end
        rd(ACR_IDX_CTSI_HI, 8'h20);
        $display("repetition done");
        finish_test();
    end
endmodule : acr_top_tb
`default_nettype wire
